// [rtl/sapr_pkg.sv]
// Package for the parallel readout of an 18-bit SAR converter core.
// Assumes a 250 MHz system clock; the conversion time is turned into cycles here.
`default_nettype none
package sapr_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Conversion time, a longest time: rounds down
  localparam int unsigned CONV_TIME_NS  = 650;
  localparam int unsigned CONV_CYCLES   =
    (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Quiet zone around the start edge, host side figures
  localparam int unsigned QUIET_PRE_NS  = 50;
  localparam int unsigned QUIET_POST_NS = 40;

  // Result width and code reset value
  localparam int unsigned RES_W         = 18;
  localparam logic [17:0] RESULT_RST    = 18'h00000;
  // Code landmarks
  localparam logic [17:0] CODE_POS_FS   = 18'h1FFFF;
  localparam logic [17:0] CODE_MID      = 18'h00000;
  localparam logic [17:0] CODE_MID_M1   = 18'h3FFFF;
  localparam logic [17:0] CODE_NEG_FS   = 18'h20000;

  // Converter control states
  typedef enum logic [1:0] {
    SAPR_IDLE = 2'b00,
    SAPR_CONV = 2'b01
  } sapr_state_e;

  // Read select group from the host
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic narrow_bus_select;
    logic byte_select;
  } sapr_sel_s;

  // Drive group towards the pins
  typedef struct packed {
    logic [17:0] data;
    logic [17:0] oe;
  } sapr_drive_s;

endpackage : sapr_pkg
`default_nettype wire

// [rtl/sapr_lane_mux.sv]
// Lane mux: maps a held 18-bit result onto the pins by select inputs.
// Purely combinational; the caller registers its output.
`default_nettype none
module sapr_lane_mux
  import sapr_pkg::*;
(
  // Held result
  input  wire logic [17:0] result_in,
  // Selects
  input  wire logic        narrow_in,
  input  wire logic        byte_in,
  // Pin pattern
  output logic      [17:0] lanes_out
);

  // Unused positions drive ones outside full-width mode
  always_comb
  begin
    case ({byte_in, narrow_in})
      2'b00: lanes_out = result_in;
      2'b01: lanes_out = {14'h3FFF, result_in[1:0], 2'h3};
      2'b10: lanes_out = {result_in[9:2], 10'h3FF};
      2'b11: lanes_out = {6'h3F, result_in[1:0], 10'h3FF};
      default: lanes_out = 18'h3FFFF;
    endcase
  end

endmodule : sapr_lane_mux
`default_nettype wire

// [rtl/sapr_readout.sv]
// Readout core of an 18-bit SAR converter: conversion timing, busy flag,
// result holding and the tri-state parallel result pins.
// Assumes all inputs are synchronous to SYS_CLK_IN; the analog core hands
// a finished code on SAR_CODE_IN when asked, and isolates the inputs while
// the sample-hold line is high.
//
// Behaviour
// - Internal conversion finishes within 650 ns.
// - Sample on start, isolate inputs while converting.
// - Drive pins only with select and read low.
// - Codes are 18-bit two's complement as given.
// - Both selects low gives full word.
// - Narrow select gives bits 1:0 on pins 3:2.
// - Byte reads: 9:2 on pins 17:10, then 1:0 on pins 11:10.
// - Unused pin positions drive ones.
// - Reads work with strobe toggled or held.
// - Start falling edge raises busy.
// - Busy falls when new result becomes readable; the pins show it one cycle after busy falls.
`default_nettype none
module sapr_readout
  import sapr_pkg::*;
#(
  parameter int unsigned CONV_CNT = CONV_CYCLES  // Cycles per conversion
)
(
  // Clock and reset
  input  wire logic                SYS_CLK_IN,
  input  wire logic                RST_N_IN,
  // Conversion control
  input  wire logic                CONVERT_START_N_IN,
  input  wire logic [17:0]         SAR_CODE_IN,
  // Host read selects
  input  wire sapr_pkg::sapr_sel_s SEL_IN,
  // Status and analog-side control
  output logic                     BUSY_OUT,
  output logic                     SAMPLE_HOLD_OUT,
  // Parallel result pins, split into value and enable
  output logic [17:0]              PARALLEL_RESULT_PINS_OUT,
  output logic [17:0]              PARALLEL_RESULT_PINS_OE_OUT
);

  // Counter width for the conversion timer
  localparam int unsigned CW = $clog2(CONV_CNT + 1);
  // Busy cycles after the first one, for the conversion-length check
  localparam int          CONV_LAST = CONV_CNT - 1;

  // All module state in one struct
  typedef struct packed {
    sapr_state_e  state;      // Idle or converting
    logic         start_d;    // Previous start level for edge detect
    logic [CW-1:0] cnt;       // Conversion cycles left
    logic [17:0]  result;     // Held last completed result
    logic         busy;       // Busy flag
    logic         hold;       // Inputs isolated on the capacitor array
    sapr_drive_s  drive;      // Registered pin drive
  } sapr_st_s;

  sapr_st_s st_r;    // Registered state
  sapr_st_s st_nxt;  // Next state
  logic [17:0] lanes; // Pin pattern from the lane mux
  logic start_fall;   // Falling edge of the start input

  // Lane selection kept apart so the mapping is easy to review
  sapr_lane_mux u_lane_mux
  (
    .result_in (st_r.result),
    .narrow_in (SEL_IN.narrow_bus_select),
    .byte_in   (SEL_IN.byte_select),
    .lanes_out (lanes)
  );

  // Start edge: start input is taken as synchronous already
  assign start_fall = st_r.start_d & ~CONVERT_START_N_IN;

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.start_d = CONVERT_START_N_IN;
    case (st_r.state)
      SAPR_IDLE:
      begin
        // A start edge while converting is ignored; the core cannot
        // resample mid-conversion without corrupting the array
        if (start_fall)
        begin
          st_nxt.state = SAPR_CONV;
          st_nxt.busy  = 1'b1;
          st_nxt.hold  = 1'b1;
          st_nxt.cnt   = CW'(CONV_CNT - 1);
        end
      end
      SAPR_CONV:
      begin
        if (st_r.cnt == '0)
        begin
          // Result and busy change together; the registered pins still show the old result for one cycle after busy falls
          st_nxt.state  = SAPR_IDLE;
          st_nxt.busy   = 1'b0;
          st_nxt.hold   = 1'b0;
          st_nxt.result = SAR_CODE_IN;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      default:
      begin
        st_nxt.state = SAPR_IDLE;
      end
    endcase
    // Pins follow the selects every cycle, so a held strobe works too
    st_nxt.drive.data = lanes;
    st_nxt.drive.oe   = (~SEL_IN.cs_n & ~SEL_IN.rd_n) ?
                        18'h3FFFF : 18'h00000;
  end

  // State register
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      st_r <= '{state: SAPR_IDLE, start_d: 1'b1, cnt: '0,
                result: RESULT_RST, busy: 1'b0, hold: 1'b0,
                drive: '{data: 18'h00000, oe: 18'h00000}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign BUSY_OUT                    = st_r.busy;
  assign SAMPLE_HOLD_OUT             = st_r.hold;
  assign PARALLEL_RESULT_PINS_OUT    = st_r.drive.data;
  assign PARALLEL_RESULT_PINS_OE_OUT = st_r.drive.oe;

  // Busy check over the first 8 cycles after a start
  sequence s_start;
    start_fall && st_r.state == SAPR_IDLE;
  endsequence
  property p_conv_len;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_start |=> BUSY_OUT [*8] ##0 (BUSY_OUT[*1]);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("busy dropped too early");

  // Busy stands through every conversion cycle, not just the first few
  sequence s_busy_run;
    BUSY_OUT throughout (1'b1 ##CONV_LAST 1'b1);
  endsequence
  property p_conv_end;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_start |=> s_busy_run ##1 !BUSY_OUT;
  endproperty
  a_conv_end: assert property (p_conv_end)
    else $error("conversion not done in time");

  property p_busy_rise;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_start |=> BUSY_OUT && SAMPLE_HOLD_OUT;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy not raised on start");

  property p_hold_busy;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    SAMPLE_HOLD_OUT == BUSY_OUT;
  endproperty
  a_hold_busy: assert property (p_hold_busy)
    else $error("inputs not isolated during conversion");

  property p_oe;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    1'b1 |=> PARALLEL_RESULT_PINS_OE_OUT ==
      ($past(!SEL_IN.cs_n && !SEL_IN.rd_n) ? 18'h3FFFF : 18'h00000);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable wrong");

  property p_full;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (!SEL_IN.narrow_bus_select && !SEL_IN.byte_select)
      |=> PARALLEL_RESULT_PINS_OUT == $past(st_r.result);
  endproperty
  a_full: assert property (p_full)
    else $error("full word wrong");

  property p_narrow;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (SEL_IN.narrow_bus_select && !SEL_IN.byte_select)
      |=> PARALLEL_RESULT_PINS_OUT[3:2] == $past(st_r.result[1:0])
          && PARALLEL_RESULT_PINS_OUT[1:0] == 2'h3;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow read wrong");

  property p_byte;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (!SEL_IN.narrow_bus_select && SEL_IN.byte_select)
      |=> PARALLEL_RESULT_PINS_OUT[17:10] == $past(st_r.result[9:2])
          && PARALLEL_RESULT_PINS_OUT[9:0] == 10'h3FF;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte read wrong");

  // Last byte read: two low bits on the top lane, ones elsewhere
  property p_both;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (SEL_IN.narrow_bus_select && SEL_IN.byte_select)
      |=> PARALLEL_RESULT_PINS_OUT[11:10] == $past(st_r.result[1:0])
          && PARALLEL_RESULT_PINS_OUT[17:12] == 6'h3F
          && PARALLEL_RESULT_PINS_OUT[9:0] == 10'h3FF;
  endproperty
  a_both: assert property (p_both)
    else $error("last byte read wrong");

  // A start edge mid-conversion must not restart the timer or drop busy
  property p_refuse;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (start_fall && st_r.state == SAPR_CONV && st_r.cnt != '0)
      |=> BUSY_OUT && st_r.cnt == $past(st_r.cnt) - 1'b1;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("conversion restarted while busy");

  property p_result_hold;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !($past(BUSY_OUT) && !BUSY_OUT) |-> $stable(st_r.result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed outside completion");

endmodule : sapr_readout
`default_nettype wire

// [tb/sapr_host_bus.sv]
// Host view of the parallel result pins, built from value and enable.
// Assumes the pins come straight from the readout core, with no pull.
`default_nettype none
module sapr_host_bus
  import sapr_pkg::*;
(
  // Clock
  input  wire logic        clk_in,
  // Pins from the core
  input  wire logic [17:0] pins_in,
  input  wire logic [17:0] oe_in,
  // Level seen by the host
  output logic      [17:0] bus_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [17:0] last_r = 18'h00000;  // Last level on the bus
  // Released bits toggle, so stale data can never look valid
  always_comb bus_out = (pins_in & oe_in) | (~last_r & ~oe_in);
  // Remember the level for the next cycle
  always_ff @(posedge clk_in) last_r <= bus_out;
endmodule : sapr_host_bus
`default_nettype wire

// [tb/sapr_readout_tb.sv]
// Bench for the readout core: conversions, lane reads and resets.
// Assumes the core in rtl/ and the host bus model in tb/.
`default_nettype none
module sapr_readout_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sapr_pkg::*;
  logic        clk = 1'b0;      // 250 MHz clock
  logic        rst_n = 1'b0;    // Reset, active low
  logic        start_n = 1'b1;  // Start strobe
  logic [17:0] code = 18'h00000;
  sapr_sel_s   sel = 4'hC;      // Idle: not selected
  logic        busy;
  logic        hold;
  logic [17:0] pins;
  logic [17:0] oe;
  logic [17:0] bus;
  int          mismatches = 0;
  int          n_compared = 0;
  int          seed = 32'h7D99;
  logic [17:0] q[$];            // Codes awaiting completion
  logic [17:0] res;             // Result the host should read
  logic [17:0] marks[4] = '{CODE_POS_FS, CODE_MID, CODE_MID_M1,
                            CODE_NEG_FS};
  // Free-running clock
  always #2 clk = ~clk;
  sapr_readout #(.CONV_CNT(CONV_CYCLES)) u_dut (.SYS_CLK_IN(clk),
    .RST_N_IN(rst_n), .CONVERT_START_N_IN(start_n), .SAR_CODE_IN(code),
    .SEL_IN(sel), .BUSY_OUT(busy), .SAMPLE_HOLD_OUT(hold),
    .PARALLEL_RESULT_PINS_OUT(pins), .PARALLEL_RESULT_PINS_OE_OUT(oe));
  sapr_host_bus u_host (.clk_in(clk), .pins_in(pins), .oe_in(oe),
    .bus_out(bus));
  // Compare and count
  task automatic check(input string nm, input logic [17:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Verdict and stop
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Expected pin pattern; unused positions read as ones
  function automatic logic [17:0] lanes(logic [17:0] c, logic nb, by);
    lanes = 18'h3FFFF;
    if (!nb && !by) lanes = c;
    else if (nb && !by) lanes[3:2] = c[1:0];
    else if (by && !nb) lanes[17:10] = c[9:2];
    else lanes[11:10] = c[1:0];
  endfunction : lanes
  // One read: selects change, pins checked a cycle later
  task automatic rd(input logic [3:0] s);
    @(negedge clk);
    sel = s;
    @(negedge clk);
    if (s[3:2] == 2'b00)
    begin
      check("bus", bus, lanes(res, s[1], s[0]));
      check("oe", oe, 18'h3FFFF);
    end
    else
      check("oe", oe, 18'h00000);
  endtask : rd
  // One conversion, with a refused start edge while busy
  task automatic conv(input logic [17:0] c);
    int n;
    int w;
    n = 0;
    w = 0;
    repeat (QUIET_PRE_NS / 4 + 1) @(negedge clk);
    code = c;
    start_n = 1'b0;
    q.push_back(c);
    while (busy !== 1'b1 && w < 4)
    begin
      @(negedge clk);
      w++;
    end
    while (busy === 1'b1 && n < 400)
    begin
      check("hold", 18'(hold), 18'h00001);
      if (n == 3) start_n = 1'b1;
      if (n == 5) start_n = 1'b0;
      @(negedge clk);
      n++;
    end
    check("busy", 18'(n), 18'(CONV_CYCLES));
    if (n >= 400 || w >= 4)
    begin
      mismatches++;
      end_sim();
    end
    else
    begin
      res = q.pop_front();
      code = 18'($random(seed));
      start_n = 1'b1;
    end
  endtask : conv
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    check("rst oe", oe, 18'h00000);
    check("rst busy", 18'(busy), 18'h00000);
    @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      conv(i < 4 ? marks[i] : 18'($random(seed)));
      for (int k = 0; k < 4; k++) rd(4'(k));
      rd(4'b0100);
      rd(4'b0000);
      rd(4'b0100);
      rd(4'b0001);
      rd(4'b1000);
      rd(4'b1100);
    end
    rd(4'b0000);
    rst_n = 1'b0;
    #1;
    check("rst oe", oe, 18'h00000);
    check("rst busy", 18'(busy), 18'h00000);
    end_sim();
  end
endmodule : sapr_readout_tb
`default_nettype wire
